// ===== rtl/rtc_apb_slave.sv
module rtc_apb_slave (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // APB
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [rtc_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Register file side
   output rtc_pkg::rtc_wr_s                 wr,
   output logic      [7:0]                  rd_idx,
   input  wire logic [7:0]                  rd_data
);
   import rtc_pkg::*;

   logic hit;
   logic err_reg;

   assign rd_idx = paddr[9:2];
   assign hit    = rtc_mapped(paddr[9:2]) && (paddr[1:0] == 2'h0) &&
                   (paddr[ADDR_W-1:10] == '0);

   // Read data is caught in the setup cycle so the access needs no wait
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata  <= 32'h0;
         err_reg <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= (hit && !pwrite) ? {24'h0, rd_data} : 32'h0;
         err_reg <= !hit;
      end
   end

   assign pready    = 1'b1;
   assign pslverr   = psel && penable && err_reg;
   assign wr.valid  = psel && penable && pwrite && !err_reg;
   assign wr.idx    = paddr[9:2];
   assign wr.data   = pwdata[7:0];

endmodule

// ===== rtl/rtc_calendar_alarm.sv
// Operation
// - Counters advance only while run enable is set; otherwise everything holds.
// - Counter writes within 300 us of enabling are ignored.
// - Counting clock is the crystal, or the RC oscillator divided by 4.
// - Time write enable gates writes to all time counter registers.
// - Write enable clears itself 50 us after it is set or a counter write; here any non-control register write while counter writes are open restarts it too.
// - Out-of-range second, minute, hour writes saturate at the highest legal value.
// - Writing second, minute, hour or week clears the sub-second counter.
// - All counters are readable at any time.
// - Alarm match sets the alarm flag and requests an interrupt.
// - Alarm registers accept writes without write enable.
// - Per-field compare enables; a disabled field always matches.
// - Alarm fires once per day or periodically, by compares enabled.
// - Control bit 6 enables the sub-second interrupt.
// - Unit keeps running in low-power modes and raises a wake event.
// - Control bit 5 enables the half-second interrupt.
// - Sub-second interval is threshold plus one times 128 counting clocks.
// - Each interrupt flag clears when software writes 1 to it.
// - Seconds and minutes count 0 to 59; sub-second steps every 1/256 s.
//
// Chosen here: the APB interface to the registers.
module rtc_calendar_alarm #(
   parameter int GUARD_CYC  = rtc_pkg::GUARD_CYCLES,
   parameter int WINDOW_CYC = rtc_pkg::WINDOW_CYCLES
) (
   // Clock and reset
   input  wire logic                        SYS_CLK,
   input  wire logic                        RST,
   // APB
   input  wire logic                        PSEL,
   input  wire logic                        PENABLE,
   input  wire logic                        PWRITE,
   input  wire logic [rtc_pkg::ADDR_W-1:0]  PADDR,
   input  wire logic [31:0]                 PWDATA,
   output logic      [31:0]                 PRDATA,
   output logic                             PREADY,
   output logic                             PSLVERR,
   // Oscillator pins
   input  wire logic                        XTAL_CLK_IN,
   input  wire logic                        RC_CLK_IN,
   // Events
   output logic                             RTC_IRQ,
   output logic                             RTC_WAKE
);
   import rtc_pkg::*;

   localparam int GW = $clog2(GUARD_CYC + 1);
   localparam int WW = $clog2(WINDOW_CYC + 1);

   rtc_wr_s    wr;
   logic [7:0] rd_idx;
   logic [7:0] rd_data;
   logic       tick;

   logic [7:0]    ctl_reg;
   logic [7:0]    cfg_reg;
   logic [7:0]    ss_reg;
   rtc_time_s     tm_reg;
   logic [15:0]   day_reg;
   logic [5:0]    al_sec_reg;
   logic [5:0]    al_min_reg;
   logic [4:0]    al_hour_reg;
   logic [7:0]    thresh_reg;
   logic [6:0]    presc_reg;
   logic [7:0]    sub_cnt_reg;
   logic [2:0]    flags_reg;
   logic [2:0]    flags_next;
   logic [GW-1:0] guard_reg;
   logic [WW-1:0] win_reg;
   logic          match_reg;
   logic          irq_reg;
   logic          wake_reg;

   logic run;
   logic guard_done;
   logic cnt_wr_ok;
   logic unit_tick;
   logic sec_tick;
   logic min_tick;
   logic hour_tick;
   logic half_tick;
   logic sub_tick;
   logic match_now;
   logic alarm_rise;
   logic ctl_wr;
   logic [2:0] flag_set;
   logic [2:0] flag_clr;

   function automatic logic wr_to(rtc_wr_s w, logic [7:0] idx);
      return w.valid && (w.idx == idx);
   endfunction

   rtc_apb_slave u_apb (
      .clk     (SYS_CLK),
      .rst     (RST),
      .psel    (PSEL),
      .penable (PENABLE),
      .pwrite  (PWRITE),
      .paddr   (PADDR),
      .pwdata  (PWDATA),
      .prdata  (PRDATA),
      .pready  (PREADY),
      .pslverr (PSLVERR),
      .wr      (wr),
      .rd_idx  (rd_idx),
      .rd_data (rd_data)
   );

   rtc_tick_gen u_tick (
      .clk      (SYS_CLK),
      .rst      (RST),
      .xtal_clk (XTAL_CLK_IN),
      .rc_clk   (RC_CLK_IN),
      .use_rc   (cfg_reg[CFG_RC]),
      .tick     (tick)
   );

   // ************************************************************
   // Time base
   // ************************************************************
   assign run       = ctl_reg[CTL_RUN];
   assign unit_tick = run && tick && (presc_reg == 7'(PRESC_DIV - 1));
   assign sec_tick  = unit_tick && (ss_reg == 8'hff);
   assign min_tick  = sec_tick && (tm_reg.second == SEC_MAX);
   assign hour_tick = min_tick && (tm_reg.minute == MIN_MAX);
   assign half_tick = unit_tick && (ss_reg[6:0] == HALF_PHASE);
   assign sub_tick  = unit_tick && (sub_cnt_reg == thresh_reg);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         presc_reg   <= 7'h0;
         sub_cnt_reg <= 8'h0;
      end else if (run && tick) begin
         presc_reg   <= presc_reg + 7'h1;
         if (unit_tick) begin
            sub_cnt_reg <= sub_tick ? 8'h0 : sub_cnt_reg + 8'h1;
         end
      end
   end

   // ************************************************************
   // Control and write window
   // ************************************************************
   assign ctl_wr     = wr_to(wr, IDX_CONTROL);
   assign guard_done = (guard_reg == GW'(GUARD_CYC));
   assign cnt_wr_ok  = run && guard_done && ctl_reg[CTL_WE];

   always_ff @(posedge SYS_CLK) begin
      if (RST || !run) begin
         guard_reg <= '0;
      end else if (!guard_done) begin
         guard_reg <= guard_reg + GW'(1);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         win_reg <= '0;
      end else if ((ctl_wr && wr.data[CTL_WE]) ||
                   (cnt_wr_ok && wr.valid && (wr.idx != IDX_CONTROL))) begin
         win_reg <= WW'(WINDOW_CYC);
      end else if (win_reg != '0) begin
         win_reg <= win_reg - WW'(1);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ctl_reg <= RST_BYTE;
      end else if (ctl_wr) begin
         ctl_reg <= wr.data & CTL_MASK;
      end else if (win_reg == WW'(1)) begin
         ctl_reg[CTL_WE] <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg_reg <= RST_BYTE;
      end else if (wr_to(wr, IDX_CONFIG)) begin
         cfg_reg <= {7'h0, wr.data[CFG_RC]};
      end
   end

   // ************************************************************
   // Time counters
   // ************************************************************
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ss_reg <= RST_BYTE;
      end else if (cnt_wr_ok && wr_to(wr, IDX_SUBSEC)) begin
         ss_reg <= wr.data;
      end else if (cnt_wr_ok && (wr_to(wr, IDX_SECOND) || wr_to(wr, IDX_MINUTE) ||
                                 wr_to(wr, IDX_HOUR))) begin
         ss_reg <= 8'h0;
      end else if (unit_tick) begin
         ss_reg <= ss_reg + 8'h1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         tm_reg <= '0;
      end else begin
         // Software write wins over a carry arriving in the same cycle
         if (cnt_wr_ok && wr_to(wr, IDX_SECOND)) begin
            tm_reg.second <= rtc_clamp6(wr.data[5:0], SEC_MAX);
         end else if (sec_tick) begin
            tm_reg.second <= min_tick ? 6'h0 : tm_reg.second + 6'h1;
         end
         if (cnt_wr_ok && wr_to(wr, IDX_MINUTE)) begin
            tm_reg.minute <= rtc_clamp6(wr.data[5:0], MIN_MAX);
         end else if (min_tick) begin
            tm_reg.minute <= hour_tick ? 6'h0 : tm_reg.minute + 6'h1;
         end
         if (cnt_wr_ok && wr_to(wr, IDX_HOUR)) begin
            tm_reg.hour <= rtc_clamp5(wr.data[4:0], HOUR_MAX);
            tm_reg.week <= wr.data[7:HOUR_LSB];
         end else if (hour_tick) begin
            tm_reg.hour <= (tm_reg.hour == HOUR_MAX) ? 5'h0 : tm_reg.hour + 5'h1;
            // Week zero means week counting is off
            if ((tm_reg.hour == HOUR_MAX) && (tm_reg.week != WEEK_OFF)) begin
               tm_reg.week <= (tm_reg.week == WEEK_MAX) ? WEEK_MIN : tm_reg.week + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         day_reg <= 16'h0;
      end else if (cnt_wr_ok && wr_to(wr, IDX_DAY_LOW)) begin
         day_reg[7:0] <= wr.data;
      end else if (cnt_wr_ok && wr_to(wr, IDX_DAY_HIGH)) begin
         day_reg[15:8] <= wr.data;
      end else if (hour_tick && (tm_reg.hour == HOUR_MAX)) begin
         day_reg <= day_reg + 16'h1;
      end
   end

   // ************************************************************
   // Alarm and threshold
   // ************************************************************
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         al_sec_reg  <= 6'h0;
         al_min_reg  <= 6'h0;
         al_hour_reg <= 5'h0;
         thresh_reg  <= RST_BYTE;
      end else begin
         if (wr_to(wr, IDX_AL_SEC)) al_sec_reg <= rtc_clamp6(wr.data[5:0], SEC_MAX);
         if (wr_to(wr, IDX_AL_MIN)) al_min_reg <= rtc_clamp6(wr.data[5:0], MIN_MAX);
         if (wr_to(wr, IDX_AL_HOUR)) al_hour_reg <= rtc_clamp5(wr.data[4:0], HOUR_MAX);
         if (wr_to(wr, IDX_THRESH)) thresh_reg <= wr.data;
      end
   end

   assign match_now = (!ctl_reg[CTL_SCE] || (tm_reg.second == al_sec_reg)) &&
                      (!ctl_reg[CTL_MCE] || (tm_reg.minute == al_min_reg)) &&
                      (!ctl_reg[CTL_HCE] || (tm_reg.hour == al_hour_reg));
   // Edge of a match: one event per minute, hour or day as enables choose
   assign alarm_rise = run && match_now && !match_reg;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         match_reg <= 1'b0;
      end else if (run) begin
         match_reg <= match_now;
      end
   end

   // ************************************************************
   // Flags, interrupt and wake
   // ************************************************************
   assign flag_set = {sub_tick && ctl_reg[CTL_SUBIE],
                      half_tick && ctl_reg[CTL_HALFE],
                      alarm_rise};
   assign flag_clr = wr_to(wr, IDX_FLAGS) ? wr.data[2:0] : 3'h0;
   // A new event wins over a clear in the same cycle
   assign flags_next = (flags_reg & ~flag_clr) | flag_set;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         flags_reg <= 3'h0;
         irq_reg   <= 1'b0;
         wake_reg  <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         irq_reg   <= |flags_next;
         wake_reg  <= |flag_set;
      end
   end

   assign RTC_IRQ  = irq_reg;
   assign RTC_WAKE = wake_reg;

   // ************************************************************
   // Register read
   // ************************************************************
   always_comb begin
      unique case (rd_idx)
         IDX_CONTROL:  rd_data = ctl_reg;
         IDX_CONFIG:   rd_data = cfg_reg;
         IDX_SUBSEC:   rd_data = ss_reg;
         IDX_SECOND:   rd_data = {2'h0, tm_reg.second};
         IDX_MINUTE:   rd_data = {2'h0, tm_reg.minute};
         IDX_HOUR:     rd_data = {tm_reg.week, tm_reg.hour};
         IDX_DAY_LOW:  rd_data = day_reg[7:0];
         IDX_DAY_HIGH: rd_data = day_reg[15:8];
         IDX_AL_SEC:   rd_data = {2'h0, al_sec_reg};
         IDX_AL_MIN:   rd_data = {2'h0, al_min_reg};
         IDX_AL_HOUR:  rd_data = {3'h0, al_hour_reg};
         IDX_THRESH:   rd_data = thresh_reg;
         IDX_FLAGS:    rd_data = {5'h0, flags_reg};
         default:      rd_data = 8'h00;
      endcase
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence s_sec_write_big;
      cnt_wr_ok && wr_to(wr, IDX_SECOND) && (wr.data[5:0] > SEC_MAX);
   endsequence

   sequence s_time_write;
      cnt_wr_ok && (wr_to(wr, IDX_MINUTE) || wr_to(wr, IDX_HOUR));
   endsequence

   a_hold_when_off: assert property (!run && !wr.valid |=> $stable(ss_reg) && $stable(tm_reg))
      else $error("time moved while stopped");
   a_guard_blocks: assert property (run && !guard_done && wr_to(wr, IDX_SECOND) && !sec_tick
      |=> $stable(tm_reg.second))
      else $error("second write taken inside guard");
   a_we_gates: assert property (!ctl_reg[CTL_WE] && wr_to(wr, IDX_SECOND) && !sec_tick
      |=> $stable(tm_reg.second))
      else $error("second write taken without write enable");
   a_we_self_clear: assert property (win_reg == WW'(1) && !ctl_wr |=> !ctl_reg[CTL_WE])
      else $error("write enable did not clear");
   a_clamp_sec: assert property (s_sec_write_big |=> tm_reg.second == SEC_MAX)
      else $error("second not saturated");
   a_ss_cleared: assert property (s_time_write |=> ss_reg == 8'h0)
      else $error("sub-second not cleared");
   a_alarm_irq: assert property (alarm_rise |=> flags_reg[FLG_ALARM] ##0 RTC_IRQ)
      else $error("alarm flag or irq missing");
   a_sub_gated: assert property (!ctl_reg[CTL_SUBIE] && !flags_reg[FLG_SUB]
      |=> !flags_reg[FLG_SUB])
      else $error("sub-second flag without enable");
   a_wake_pulse: assert property (flag_set != 3'h0 |=> RTC_WAKE)
      else $error("no wake pulse");
   a_flag_w1c: assert property (wr_to(wr, IDX_FLAGS) && wr.data[FLG_HALF] && !half_tick
      |=> !flags_reg[FLG_HALF])
      else $error("half flag not cleared");
   a_sec_range: assert property (tm_reg.second <= SEC_MAX && tm_reg.minute <= MIN_MAX)
      else $error("second or minute out of range");

endmodule

// ===== rtl/rtc_pkg.sv
package rtc_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_HZ        = 50_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int GUARD_NS      = 300_000;
   // Least time, rounded up
   localparam int GUARD_CYCLES  = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WINDOW_NS     = 50_000;
   // Longest time, rounded down
   localparam int WINDOW_CYCLES = WINDOW_NS / CLK_PERIOD_NS;
   localparam int PRESC_DIV     = 128;
   localparam int RC_DIV        = 4;
   localparam int ADDR_W        = 12;

   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] IDX_CONTROL  = 8'hf1;
   localparam logic [7:0] IDX_SUBSEC   = 8'he9;
   localparam logic [7:0] IDX_SECOND   = 8'hf2;
   localparam logic [7:0] IDX_MINUTE   = 8'hf3;
   localparam logic [7:0] IDX_HOUR     = 8'hf4;
   localparam logic [7:0] IDX_DAY_LOW  = 8'hf5;
   localparam logic [7:0] IDX_DAY_HIGH = 8'hf6;
   localparam logic [7:0] IDX_AL_SEC   = 8'hea;
   localparam logic [7:0] IDX_AL_MIN   = 8'heb;
   localparam logic [7:0] IDX_AL_HOUR  = 8'hec;
   localparam logic [7:0] IDX_THRESH   = 8'hed;
   localparam logic [7:0] IDX_FLAGS    = 8'hee;
   localparam logic [7:0] IDX_CONFIG   = 8'hef;

   // ************************************************************
   // Fields and reset values
   // ************************************************************
   localparam int CTL_RUN   = 7;
   localparam int CTL_SUBIE = 6;
   localparam int CTL_HALFE = 5;
   localparam int CTL_SCE   = 4;
   localparam int CTL_MCE   = 3;
   localparam int CTL_HCE   = 2;
   localparam int CTL_WE    = 1;
   localparam logic [7:0] CTL_MASK  = 8'hfe;
   localparam int FLG_SUB   = 2;
   localparam int FLG_HALF  = 1;
   localparam int FLG_ALARM = 0;
   localparam int CFG_RC    = 0;
   localparam int HOUR_LSB  = 5;
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [5:0] SEC_MAX   = 6'd59;
   localparam logic [5:0] MIN_MAX   = 6'd59;
   localparam logic [4:0] HOUR_MAX  = 5'd23;
   localparam logic [2:0] WEEK_OFF  = 3'd0;
   localparam logic [2:0] WEEK_MIN  = 3'd1;
   localparam logic [2:0] WEEK_MAX  = 3'd7;
   localparam logic [6:0] HALF_PHASE = 7'h7f;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [2:0] week;
      logic [4:0] hour;
      logic [5:0] minute;
      logic [5:0] second;
   } rtc_time_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] idx;
      logic [7:0] data;
   } rtc_wr_s;

   // Out-of-range values saturate at the highest legal value
   function automatic logic [5:0] rtc_clamp6(logic [5:0] v, logic [5:0] m);
      return (v > m) ? m : v;
   endfunction

   function automatic logic [4:0] rtc_clamp5(logic [4:0] v, logic [4:0] m);
      return (v > m) ? m : v;
   endfunction

   function automatic logic rtc_mapped(logic [7:0] idx);
      return (idx == IDX_CONTROL) || (idx == IDX_CONFIG) ||
             ((idx >= IDX_SUBSEC) && (idx <= IDX_FLAGS)) ||
             ((idx >= IDX_SECOND) && (idx <= IDX_DAY_HIGH));
   endfunction

endpackage

// ===== rtl/rtc_tick_gen.sv
module rtc_tick_gen (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Oscillator pins and source select
   input  wire logic xtal_clk,
   input  wire logic rc_clk,
   input  wire logic use_rc,
   // One pulse per counting clock period
   output logic      tick
);
   import rtc_pkg::*;

   logic [2:0] xtal_sync_reg;
   logic [2:0] rc_sync_reg;
   logic [1:0] rc_div_reg;
   logic       xtal_edge;
   logic       rc_edge;

   // Pins are asynchronous; stage 0 feeds stage 1 only
   always_ff @(posedge clk) begin
      if (rst) begin
         xtal_sync_reg <= 3'h0;
         rc_sync_reg   <= 3'h0;
      end else begin
         xtal_sync_reg <= {xtal_sync_reg[1:0], xtal_clk};
         rc_sync_reg   <= {rc_sync_reg[1:0], rc_clk};
      end
   end

   assign xtal_edge = xtal_sync_reg[1] & ~xtal_sync_reg[2];
   assign rc_edge   = rc_sync_reg[1] & ~rc_sync_reg[2];

   always_ff @(posedge clk) begin
      if (rst) begin
         rc_div_reg <= 2'h0;
      end else if (rc_edge) begin
         rc_div_reg <= (rc_div_reg == 2'(RC_DIV - 1)) ? 2'h0 : rc_div_reg + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tick <= 1'b0;
      end else if (use_rc) begin
         tick <= rc_edge && (rc_div_reg == 2'(RC_DIV - 1));
      end else begin
         tick <= xtal_edge;
      end
   end

endmodule

// ===== sim/rtc_calendar_alarm_test.sv
module rtc_calendar_alarm_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rtc_pkg::*;

   // ************************************************************
   // Bench signals
   // ************************************************************
   localparam int GUARD_C  = 20;
   localparam int WINDOW_C = 10;
   logic              SYS_CLK, RST, PSEL, PENABLE, PWRITE;
   logic [ADDR_W-1:0] PADDR;
   logic [31:0]       PWDATA, PRDATA, r;
   logic              PREADY, PSLVERR, XTAL_CLK_IN, RC_CLK_IN, RTC_IRQ, RTC_WAKE, e, osc_on;
   logic [1:0]        div;
   int                n_mismatch, checked, n_wake, cyc, t0;

   rtc_calendar_alarm #(.GUARD_CYC(GUARD_C), .WINDOW_CYC(WINDOW_C)) dut_u (
      .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .XTAL_CLK_IN(XTAL_CLK_IN), .RC_CLK_IN(RC_CLK_IN), .RTC_IRQ(RTC_IRQ), .RTC_WAKE(RTC_WAKE));

   initial begin
      SYS_CLK = 1'b0;
      forever #10 SYS_CLK = ~SYS_CLK;
   end

   // Oscillators stand still while osc_on is low
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (RTC_WAKE === 1'b1) n_wake <= n_wake + 1;
      if (osc_on) div <= div + 2'h1;
      XTAL_CLK_IN <= div[1];
      RC_CLK_IN <= div[1];
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // Idle edge first, so a release and the next setup never share a time step
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= {2'b00, idx, 2'b00};
      PWDATA <= {24'h0, d};
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge SYS_CLK);
      end while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(r, {24'h0, exp});
   endtask

   task automatic spin(input int n);
      osc_on <= 1'b1;
      repeat (n) @(posedge SYS_CLK);
      osc_on <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
   endtask

   // Second steps 10 to 11 once the forced sub-second wraps
   task automatic alarm(input logic [7:0] ctl, input logic [7:0] amin, input logic exp);
      wr(IDX_CONTROL, ctl | 8'h02);
      wr(IDX_SECOND, 8'h0a);
      wr(IDX_SUBSEC, 8'hff);
      wr(IDX_AL_SEC, 8'h0b);
      wr(IDX_AL_MIN, amin);
      wr(IDX_FLAGS, 8'h07);
      spin(560);
      apb(1'b0, IDX_FLAGS, 8'h00);
      chkb(r[FLG_ALARM], exp);
   endtask

   task automatic wait_sub;
      do begin
         apb(1'b0, IDX_FLAGS, 8'h00);
      end while (r[FLG_SUB] !== 1'b1);
   endtask

   task automatic print_verdict;
      $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      {RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 3'b000, 12'h000, 32'h0};
      {osc_on, div, XTAL_CLK_IN, RC_CLK_IN, n_mismatch, checked, n_wake, cyc} = '0;
      repeat (20) @(posedge SYS_CLK);
      RST <= 1'b0;
      rdc(IDX_CONTROL, RST_BYTE);
      rdc(IDX_HOUR, RST_BYTE);
      apb(1'b0, 8'h10, 8'h00);
      chkb(e, 1'b1);
      wr(IDX_CONTROL, 8'h02);
      wr(IDX_SECOND, 8'h05);
      spin(600);
      rdc(IDX_SECOND, 8'h00);
      rdc(IDX_SUBSEC, 8'h00);
      // Crystal runs before the unit is first enabled
      osc_on <= 1'b1;
      wr(IDX_CONTROL, 8'h82);
      wr(IDX_SECOND, 8'h05);
      rdc(IDX_SECOND, 8'h00);
      repeat (GUARD_C + WINDOW_C + 5) @(posedge SYS_CLK);
      rdc(IDX_CONTROL, 8'h80);
      wr(IDX_SECOND, 8'h05);
      rdc(IDX_SECOND, 8'h00);
      wr(IDX_AL_SEC, 8'h3f);
      rdc(IDX_AL_SEC, 8'h3b);
      wr(IDX_CONTROL, 8'h82);
      wr(IDX_SUBSEC, 8'h40);
      wr(IDX_SECOND, 8'h3f);
      rdc(IDX_SUBSEC, 8'h00);
      rdc(IDX_SECOND, 8'h3b);
      wr(IDX_CONTROL, 8'ha2);
      wr(IDX_MINUTE, 8'h3f);
      wr(IDX_HOUR, 8'hff);
      wr(IDX_SECOND, 8'h3b);
      wr(IDX_DAY_LOW, 8'hff);
      wr(IDX_SUBSEC, 8'hff);
      rdc(IDX_MINUTE, 8'h3b);
      rdc(IDX_HOUR, 8'hf7);
      // Match with no compares enabled rose at enable
      wr(IDX_FLAGS, 8'h07);
      spin(540);
      rdc(IDX_SECOND, 8'h00);
      rdc(IDX_MINUTE, 8'h00);
      rdc(IDX_HOUR, 8'h20);
      rdc(IDX_DAY_HIGH, 8'h01);
      rdc(IDX_FLAGS, 8'h02);
      chkb(RTC_IRQ, 1'b1);
      wr(IDX_FLAGS, 8'h02);
      rdc(IDX_FLAGS, 8'h00);
      chkb(RTC_IRQ, 1'b0);
      alarm(8'h90, 8'h05, 1'b1);
      alarm(8'h98, 8'h05, 1'b0);
      alarm(8'h9c, 8'h00, 1'b1);
      chkb(n_wake > 0, 1'b1);
      wr(IDX_THRESH, 8'h01);
      wr(IDX_CONTROL, 8'hc0);
      osc_on <= 1'b1;
      wait_sub();
      wr(IDX_FLAGS, 8'h04);
      t0 = cyc;
      wait_sub();
      chkb((cyc - t0) >= 1005 && (cyc - t0) <= 1040, 1'b1);
      wr(IDX_CONTROL, 8'h80);
      wr(IDX_FLAGS, 8'h07);
      repeat (1100) @(posedge SYS_CLK);
      apb(1'b0, IDX_FLAGS, 8'h00);
      chkb(r[FLG_SUB], 1'b0);
      osc_on <= 1'b0;
      wr(IDX_CONFIG, 8'h01);
      wr(IDX_CONTROL, 8'h82);
      wr(IDX_SUBSEC, 8'h10);
      spin(2100);
      apb(1'b0, IDX_SUBSEC, 8'h00);
      chkb(r === 32'h11 || r === 32'h12, 1'b1);
      print_verdict();
   end

   // Whole run is about 8k cycles
   initial begin
      repeat (40000) @(posedge SYS_CLK);
      n_mismatch++;
      print_verdict();
   end
endmodule
